/* inc/sasr_pkg.sv */
// Shared constants and types for the converter serial readout link
package sasr_pkg;
  localparam int CLK_NS = 25;
  localparam int T_CONV_MIN_NS = 700;
  localparam int T_CONV_MAX_NS = 3200;
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_NS;
  localparam int SYNC_LAT_CYC = 3;
  localparam int RES_W = 16;
  localparam int CHAIN_STAGES = 16;
  localparam logic [15:0] CODE_MAX = 16'h7fff;
  localparam logic [15:0] CODE_MIN = 16'h8000;
  localparam int SCLK_HALF_CYC = 8;
  localparam int SETUP_CYC = 4;
  localparam int HOLD_CYC = 4;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [0:0]
  {
    DEV_IDLE = 1'b0,
    DEV_CONV = 1'b1
  } sasr_dev_state_t;

  typedef enum logic [2:0]
  {
    HST_IDLE = 3'b000,
    HST_SETUP = 3'b001,
    HST_CONV = 3'b010,
    HST_SHIFT = 3'b011,
    HST_DONE = 3'b100
  } sasr_host_state_t;
endpackage

/* inc/sasr_link_if.sv */
// Four-wire link between host and converter, with output resolution
`timescale 1ns/1ps
interface sasr_link_if;
  logic convStart;
  logic sclk;
  logic serialInModeSelect;
  logic serialOut;
  logic serialOutEn;
  logic sdoLine;

  // Undriven line floats high through the board pull-up
  assign sdoLine = serialOutEn ? serialOut : 1'b1;

  modport device
  (
    input convStart,
    input sclk,
    input serialInModeSelect,
    output serialOut,
    output serialOutEn
  );

  modport host
  (
    output convStart,
    output sclk,
    output serialInModeSelect,
    input sdoLine
  );
endinterface

/* design/sasr_device.sv */
// Converter end: conversion timing, mode capture and serial result output
// How it works
// - Rising convert_start starts conversion, latches mode
// - Mode select low at edge: daisy chain
// - Mode select high at edge: select gated
// - Select gated: output floats only while start and select both high
// - Select gated: either line low enables output
// - Chain: data presented while start held high
// - Result shifts out on external serial clock
// - Chain: mode select line becomes data input
// - Chain: input reappears after sixteen clocks
// - Chain: clock high at edge enables busy
// - Select gated: low line at completion enables busy
// - Busy enabled: output flags completion before data
// - Result ready 0.7 to 3.2 us after edge
// - Most significant bit shifted out first
// - Two's complement code, saturating at range ends
`timescale 1ns/1ps
module sasr_device
  import sasr_pkg::*;
#(
  parameter int CONV_CYC = CONV_MIN_CYC,
  parameter int IN_W = 18
)
(
  input wire logic clk,
  input wire logic resetn,
  sasr_link_if.device lnk,
  input wire logic [IN_W-1:0] analogIn,
  output logic converting,
  output logic [RES_W-1:0] lastCode,
  output logic selGatedMode,
  output logic busyEnabled
);

  if (CONV_CYC < CONV_MIN_CYC || CONV_CYC + SYNC_LAT_CYC > CONV_MAX_CYC)
  begin : g_bad_conv
    $error("sasr_device: CONV_CYC outside conversion window");
  end
  if (IN_W <= RES_W)
  begin : g_bad_width
    $error("sasr_device: IN_W must exceed the result width");
  end

  // The link clock may fall only once the frame clear is up, so the
  // host's hold after the start edge must outlast the start sync.
  if (HOLD_CYC <= SYNC_LAT_CYC)
  begin : g_bad_hold
    $error("sasr_device: serial clock hold shorter than start sync");
  end

  typedef struct packed {
    logic [1:0] cnvSync;
    logic [1:0] sdiSync;
    logic [1:0] sclkSync;
    logic cnvPrev;
    sasr_dev_state_t state;
    logic [7:0] cnt;
    logic selGated;
    logic busyEn;
    logic [RES_W-1:0] sample;
    logic [RES_W-1:0] code;
    logic frameClr;
  } sasr_core_t;

  typedef struct packed {
    logic [4:0] bitCnt;
    logic [CHAIN_STAGES-1:0] chainSr;
  } sasr_shift_t;

  sasr_core_t q;
  sasr_core_t d;
  sasr_shift_t sq;
  sasr_shift_t sd;
  logic cnvRise;
  logic outBit;
  logic [4:0] dataIdx;

  // Clamp the wide sampled value into the 16-bit signed code range
  function automatic logic [RES_W-1:0] sasr_sat(input logic [IN_W-1:0] v);
    logic [IN_W-RES_W:0] top;
    top = v[IN_W-1:RES_W-1];
    if (top == '0 || top == '1)
    begin
      sasr_sat = v[RES_W-1:0];
    end
    else if (v[IN_W-1])
    begin
      sasr_sat = CODE_MIN;
    end
    else
    begin
      sasr_sat = CODE_MAX;
    end
  endfunction

  assign cnvRise = q.cnvSync[1] & ~q.cnvPrev;

  always_comb
  begin
    d = q;
    d.cnvSync = {q.cnvSync[0], lnk.convStart};
    d.sdiSync = {q.sdiSync[0], lnk.serialInModeSelect};
    d.sclkSync = {q.sclkSync[0], lnk.sclk};
    d.cnvPrev = q.cnvSync[1];
    unique case (q.state)
      DEV_IDLE:
      begin
        // Only the idle state looks at edges
        if (cnvRise)
        begin
          d.state = DEV_CONV;
          d.cnt = 8'h00;
          d.frameClr = 1'b1;
          d.selGated = q.sdiSync[1];
          d.busyEn = ~q.sdiSync[1] & q.sclkSync[1];
          // Source shares this clock, so the sample needs no sync
          d.sample = sasr_sat(analogIn);
        end
      end
      DEV_CONV:
      begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(CONV_CYC - 1))
        begin
          d.state = DEV_IDLE;
          d.frameClr = 1'b0;
          d.code = q.sample;
          // Gated busy is decided at completion, not at the start edge
          if (q.selGated)
          begin
            d.busyEn = ~q.sdiSync[1] | ~q.cnvSync[1];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.selGated <= 1'b1;
      q.frameClr <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Serial clock domain: the host stops its clock outside frames, so
  // the position is cleared by the conversion itself, not by an edge.
  always_comb
  begin
    sd = sq;
    if (sq.bitCnt != 5'h1f)
    begin
      sd.bitCnt = sq.bitCnt + 5'h01;
    end
    sd.chainSr = {sq.chainSr[CHAIN_STAGES-2:0], lnk.serialInModeSelect};
  end

  // Clear comes from a flop in the core domain and is released only
  // while the host holds the serial clock still during conversion.
  always_ff @(negedge lnk.sclk or posedge q.frameClr)
  begin
    if (q.frameClr)
    begin
      sq <= '0;
    end
    else
    begin
      sq <= sd;
    end
  end

  // Result word stays put for the whole frame, so the mux below
  // crosses domains without a handshake.
  always_comb
  begin
    // Busy slot first, then sixteen data bits, then the chain path
    dataIdx = sq.bitCnt - {4'h0, q.busyEn};
    if (q.busyEn && sq.bitCnt == 5'h00)
    begin
      outBit = (q.state == DEV_CONV);
    end
    else if (dataIdx < 5'h10)
    begin
      outBit = q.code[4'hf - dataIdx[3:0]];
    end
    else
    begin
      outBit = sq.chainSr[CHAIN_STAGES-1];
    end
  end

  assign lnk.serialOut = outBit;
  // Chain mode drives all the time; gated mode only when selected
  assign lnk.serialOutEn = q.selGated ? (~q.cnvSync[1] | ~q.sdiSync[1]) : 1'b1;

  assign converting = (q.state == DEV_CONV);
  assign lastCode = q.code;
  assign selGatedMode = q.selGated;
  assign busyEnabled = q.busyEn;

endmodule // sasr_device

/* design/sasr_host.sv */
// Host end: starts conversions, clocks results in, buffers them in a FIFO
`timescale 1ns/1ps
module sasr_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("sasr_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } sasr_fifo_t;

  sasr_fifo_t q;
  sasr_fifo_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady = (q.count != (AW+1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[q.rdPtr];

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.wrPtr = q.wrPtr + 1'b1;
    end
    if (pop)
    begin
      d.rdPtr = q.rdPtr + 1'b1;
    end
    d.count = q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[q.wrPtr] <= inData;
    end
  end
endmodule // sasr_fifo

module sasr_host
  import sasr_pkg::*;
#(
  parameter int CHAIN_LEN = 1
)
(
  input wire logic clk,
  input wire logic resetn,
  sasr_link_if.host lnk,
  input wire logic startReq,
  input wire logic selGated,
  input wire logic busyReq,
  output logic [RES_W-1:0] outData,
  output logic outValid,
  input wire logic outReady,
  output logic hostBusy
);

  if (CHAIN_LEN < 1 || RES_W * CHAIN_LEN + 1 > 255)
  begin : g_bad_chain
    $error("sasr_host: CHAIN_LEN out of range");
  end

  typedef struct packed {
    sasr_host_state_t state;
    logic [7:0] cnt;
    logic [7:0] sampCnt;
    logic [3:0] wordBits;
    logic [RES_W-1:0] shift;
    logic [1:0] sdoSync;
    logic sclk;
    logic convert_start;
    logic serial_in_mode_select;
    logic sel;
    logic busy;
    logic pushValid;
    logic [RES_W-1:0] pushData;
  } sasr_hst_t;

  sasr_hst_t q;
  sasr_hst_t d;
  logic pushReady;
  logic [7:0] totalSamp;

  assign totalSamp = 8'(RES_W * CHAIN_LEN) + {7'h00, q.busy};

  always_comb
  begin
    d = q;
    d.sdoSync = {q.sdoSync[0], lnk.sdoLine};
    if (pushReady)
    begin
      d.pushValid = 1'b0;
    end
    unique case (q.state)
      HST_IDLE:
      begin
        if (startReq)
        begin
          d.state = HST_SETUP;
          d.cnt = 8'h00;
          d.sel = selGated;
          d.busy = busyReq;
          d.serial_in_mode_select = selGated;
          d.sclk = busyReq & ~selGated;
        end
      end
      HST_SETUP:
      begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(SETUP_CYC - 1))
        begin
          d.state = HST_CONV;
          d.cnt = 8'h00;
          d.convert_start = 1'b1;
        end
      end
      HST_CONV:
      begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(HOLD_CYC - 1))
        begin
          d.sclk = 1'b0;
          // Gated mode with busy: select line low at completion
          d.serial_in_mode_select = q.sel & ~q.busy;
        end
        if (q.cnt == 8'(CONV_MAX_CYC - 1))
        begin
          d.state = HST_SHIFT;
          d.cnt = 8'h00;
          d.sampCnt = 8'h00;
          d.wordBits = 4'h0;
          d.convert_start = ~q.sel;
        end
      end
      HST_SHIFT:
      begin
        // A full FIFO freezes the serial clock mid-frame
        if (!(q.pushValid && !pushReady))
        begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == 8'(SCLK_HALF_CYC - 1))
          begin
            d.cnt = 8'h00;
            d.sclk = ~q.sclk;
            if (!q.sclk)
            begin
              if (!(q.busy && q.sampCnt == 8'h00))
              begin
                d.shift = {q.shift[RES_W-2:0], q.sdoSync[1]};
                d.wordBits = q.wordBits + 4'h1;
                if (q.wordBits == 4'hf)
                begin
                  d.pushValid = 1'b1;
                  d.pushData = {q.shift[RES_W-2:0], q.sdoSync[1]};
                end
              end
            end
            else
            begin
              d.sampCnt = q.sampCnt + 8'h01;
              if (q.sampCnt == totalSamp - 8'h01)
              begin
                d.state = HST_DONE;
              end
            end
          end
        end
      end
      HST_DONE:
      begin
        if (!q.pushValid)
        begin
          d.state = HST_IDLE;
          d.convert_start = 1'b0;
          d.serial_in_mode_select = 1'b1;
        end
      end
      default:
      begin
        d.state = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.serial_in_mode_select <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  sasr_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .inData(q.pushData),
    .inValid(q.pushValid),
    .inReady(pushReady),
    .outData(outData),
    .outValid(outValid),
    .outReady(outReady)
  );

  assign lnk.convStart = q.convert_start;
  assign lnk.sclk = q.sclk;
  assign lnk.serialInModeSelect = q.serial_in_mode_select;
  assign hostBusy = (q.state != HST_IDLE);

endmodule // sasr_host

/* test/sasr_link_asserts.sv */
// Protocol checks on the link between host and converter ends
`timescale 1ns/1ps
module sasr_link_asserts
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic convStart,
  input wire logic sclk,
  input wire logic serialInModeSelect,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  logic cnvPrevQ;
  logic gatedQ;
  logic [9:0] sinceCnvQ;

  // Mirror of the mode the converter latches at each start edge
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnvPrevQ <= 1'b0;
      gatedQ <= 1'b1;
      sinceCnvQ <= 10'h3ff;
    end
    else
    begin
      cnvPrevQ <= convStart;
      if (convStart && !cnvPrevQ)
      begin
        gatedQ <= serialInModeSelect;
        sinceCnvQ <= 10'h000;
      end
      else if (sinceCnvQ != 10'h3ff)
        sinceCnvQ <= sinceCnvQ + 10'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence sSdiHold;
    serialInModeSelect == $past(serialInModeSelect, 3) ##1 $stable(serialInModeSelect) [*3];
  endsequence
  sequence sSclkHold;
    sclk == $past(sclk, 3) ##1 $stable(sclk) [*3];
  endsequence

  a_mode_setup: assert property ($rose(convStart) |-> sSdiHold)
    else $error("Mode line moved around the start edge");
  a_busy_sclk_hold: assert property ($rose(convStart) |-> sSclkHold)
    else $error("Serial clock moved around the start edge");
  // Sync latency in the converter needs a few cycles of settled input
  a_gated_release: assert property (gatedQ && convStart && serialInModeSelect [*8]
    |-> !serialOutEn)
    else $error("Gated output driven while deselected");
  a_gated_enable: assert property (gatedQ && $fell(convStart) |-> ##[1:5] serialOutEn)
    else $error("Gated output not enabled after select");
  a_chain_drive: assert property (!gatedQ && convStart [*8] |-> serialOutEn)
    else $error("Chain output not driven during read");
  a_shift_on_fall: assert property (sclk && $past(sclk) && sinceCnvQ >= 10'h080
    |-> $stable(serialOut))
    else $error("Output changed while serial clock high");
  a_read_after_conv: assert property ($rose(sclk) |-> sinceCnvQ >= 10'h07f)
    else $error("Result clocked before conversion time");
  a_start_spacing: assert property ($rose(convStart) |-> sinceCnvQ >= 10'h07f)
    else $error("Start edge during conversion window");
endmodule // sasr_link_asserts

/* test/sar_adc_serial_readout_bench.sv */
// Self-checking bench joining host and converter ends over the link
`timescale 1ns/1ps
module sar_adc_serial_readout_bench
  import sasr_pkg::*;
;
  typedef struct packed
  {
    logic sel;
    logic busy;
    logic [17:0] ain;
    logic [15:0] code;
  } sasr_row_t;
  // Mode, busy request, sample, expected code; range ends saturate
  localparam sasr_row_t ROWS [6] = '{
    '{1'b1, 1'b0, 18'h01234, 16'h1234}, '{1'b1, 1'b1, 18'h3ffff, 16'hffff},
    '{1'b0, 1'b0, 18'h1ffff, 16'h7fff}, '{1'b0, 1'b1, 18'h20000, 16'h8000},
    '{1'b1, 1'b0, 18'h08000, 16'h7fff}, '{1'b0, 1'b0, 18'h38000, 16'h8000}};
  logic clk, resetn, startReq, selGated, busyReq, outReady, outValid, hostBusy;
  logic converting, selGatedMode, busyEnabled;
  logic [17:0] analogIn;
  logic [15:0] outData, lastCode;
  logic [16:0] rxBits;
  logic [15:0] expQ [$];
  int err_count, n_tests, i;

  sasr_link_if u_sasr_link_if ();
  sasr_host #(.CHAIN_LEN(1)) u_sasr_host (.clk(clk), .resetn(resetn), .lnk(u_sasr_link_if),
    .startReq(startReq), .selGated(selGated), .busyReq(busyReq), .outData(outData),
    .outValid(outValid), .outReady(outReady), .hostBusy(hostBusy));
  sasr_device #(.CONV_CYC(CONV_MIN_CYC), .IN_W(18)) u_sasr_device (.clk(clk),
    .resetn(resetn), .lnk(u_sasr_link_if), .analogIn(analogIn), .converting(converting),
    .lastCode(lastCode), .selGatedMode(selGatedMode), .busyEnabled(busyEnabled));
  sasr_link_asserts u_sasr_link_asserts (.clk(clk), .resetn(resetn),
    .convStart(u_sasr_link_if.convStart), .sclk(u_sasr_link_if.sclk),
    .serialInModeSelect(u_sasr_link_if.serialInModeSelect),
    .serialOut(u_sasr_link_if.serialOut), .serialOutEn(u_sasr_link_if.serialOutEn));

  always #12.5 clk = ~clk;
  // Bits as seen on the resolved wire, last seventeen kept, busy slot on top
  always @(posedge u_sasr_link_if.sclk)
    rxBits <= {rxBits[15:0], u_sasr_link_if.sdoLine};

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic frame(input sasr_row_t r, input bit waitDone);
    @(negedge clk);
    selGated = r.sel;
    busyReq = r.busy;
    analogIn = r.ain;
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
    expQ.push_back(r.code);
    for (i = 0; waitDone && hostBusy !== 1'b0 && i < 2000; i++)
      @(negedge clk);
    if (waitDone)
    begin
      chk1(hostBusy, 1'b0);
      chk16(rxBits[15:0], r.code);
      if (r.busy) chk1(rxBits[16], 1'b0);
      if (!r.sel) chk1(u_sasr_link_if.sdoLine, 1'b0);
      chk16(lastCode, r.code);
      chk1(busyEnabled, r.busy);
      chk1(selGatedMode, r.sel);
    end
  endtask

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {startReq, selGated, busyReq, outReady} = 4'h0;
    analogIn = 18'h00000;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    foreach (ROWS[k])
      frame(ROWS[k], 1'b1);
    // Sixteen words fill the buffer; the next frame must stall on the link
    for (int k = 0; k < 10; k++)
      frame(ROWS[k % 6], 1'b1);
    frame(ROWS[0], 1'b0);
    repeat (800) @(negedge clk);
    chk1(hostBusy, 1'b1);
    for (int k = 0; k < 17; k++)
    begin
      for (i = 0; outValid !== 1'b1 && i < 2000; i++)
        @(negedge clk);
      chk1(outValid, 1'b1);
      chk16(outData, expQ.pop_front());
      outReady = 1'b1;
      @(negedge clk);
      outReady = 1'b0;
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    chk1(outValid, 1'b0);
    // Reset landing in mid-conversion
    selGated = 1'b1;
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
    repeat (12) @(negedge clk);
    chk1(converting, 1'b1);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk1(converting, 1'b0);
    chk16(lastCode, 16'h0000);
    chk1(selGatedMode, 1'b1);
    chk1(busyEnabled, 1'b0);
    chk1(u_sasr_link_if.convStart, 1'b0);
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    frame(ROWS[3], 1'b1);
    stop_test();
  end

  initial
  begin
    #750000;
    err_count++;
    stop_test();
  end
endmodule // sar_adc_serial_readout_bench
